/* File: common/rcb_pkg.sv */
// Constants and types shared by the receive cell bus output block
// Overview of operation
// RL1 - Cell-available output tells the ATM layer that buffered cell data is readable.
// RL2 - Control bit 7 selects level 3 signaling at 0, level 1/2 at 1.
// RL3 - Bus width field bits 3:2: 00 inactive, 01 8-bit, 10 16-bit, 11 invalid.
// RL4 - In 8-bit width only lanes 15:8 are driven; lanes 7:0 stay inactive.
// RL5 - In 16-bit width all sixteen data lanes are driven during transfer.
// RL6 - 8-bit width carries 52-octet cells or 53-octet cells with header check byte.
// RL7 - 16-bit width carries 52-octet cells or 54-octet cells with check and stuff byte.
// RL8 - Cell size field bits 1:0: 00 52, 01 53, 10 54 octets, 11 unused.
// RL9 - Exactly the selected number of octets is transferred for every cell.
// RL10 - Only cell-level handshaking exists; no octet-level handshake in any mode.
// RL11 - Cell-available is 1 while at least one complete cell waits in the buffer.
// RL12 - Cell-available drops once less than one complete cell remains; the code keeps it high while the buffer is full.
// RL13 - The ATM layer watches cell-available and reads promptly when it is high.
// RL14 - Start-of-cell is high one interface clock period with each cell's first word.
// RL15 - Odd parity over each driven byte or word appears beside the data.
// RL16 - Data outputs change on the rising edge of the interface clock.
// RL17 - Data bus floats while read enable is high; ATM layer pulls it low to read.
// RL18 - Inactive or invalid width: no cells delivered and cell-available kept low.
// RL19 - Multi-PHY, back-to-back polling and direct status bits are only stored.
package rcb_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] RX_CELL_BUS_CONTROL_OFS = 16'h0403;
    // Level and width come up as "1" and inactive; size field comes up as 11
    localparam logic [7:0] RX_CELL_BUS_CONTROL_RST = 8'h83;
    localparam int CTRL_LEVEL_BIT = 7;
    localparam int CTRL_MULTI_PHY_BIT = 6;
    localparam int CTRL_B2B_POLL_BIT = 5;
    localparam int CTRL_DIRECT_STAT_BIT = 4;
    localparam int CTRL_WIDTH_LSB = 2;
    localparam int CTRL_SIZE_LSB = 0;

    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] WIDTH_INACTIVE = 2'h0;
    localparam logic [1:0] WIDTH_8 = 2'h1;
    localparam logic [1:0] WIDTH_16 = 2'h2;
    localparam logic [1:0] SIZE_52 = 2'h0;
    localparam logic [1:0] SIZE_53 = 2'h1;
    localparam logic [1:0] SIZE_54 = 2'h2;

    // Bus words per cell for each legal width and size pairing
    localparam logic [5:0] WORDS_8_52 = 6'h34;
    localparam logic [5:0] WORDS_8_53 = 6'h35;
    localparam logic [5:0] WORDS_16_52 = 6'h1A;
    localparam logic [5:0] WORDS_16_54 = 6'h1B;
    localparam logic [5:0] WORDS_NONE = 6'h00;

    // ------------------------------------------------------------
    // Buffer and bus geometry
    // ------------------------------------------------------------
    localparam int BUS_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int CELL_CNT_W = 8;
    localparam logic [CELL_CNT_W-1:0] CELL_CNT_RST = 8'h00;

    typedef enum logic [1:0] {RCB_IDLE, RCB_IN_CELL} rcb_rd_state_t;

endpackage

/* File: common/rcb_fifo_if.sv */
// Carrier between the cell bus output logic and its word buffer
`timescale 1ns/10ps
interface rcb_fifo_if #(
    parameter int WIDTH = 16
);
    logic wrValid;
    logic wrReady;
    logic [WIDTH-1:0] wrData;
    logic rdValid;
    logic rdReady;
    logic [WIDTH-1:0] rdData;
    logic full;

    modport store (input wrValid, output wrReady, input wrData,
                   output rdValid, input rdReady, output rdData, output full);
    modport user (output wrValid, input wrReady, output wrData,
                  input rdValid, output rdReady, input rdData, input full);
endinterface

/* File: rtl/rcb_fifo.sv */
// Word buffer between cell processor and cell bus, registered read stage
`timescale 1ns/10ps
module rcb_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rstn,
    rcb_fifo_if.store port
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    logic [WIDTH-1:0] outData_r;
    logic outValid_r;
    logic doWrite;
    logic doLoad;

    // The output register counts as one more entry, so DEPTH words plus one can wait
    assign port.wrReady = (count_r != (AW+1)'(DEPTH));
    assign port.full = !port.wrReady;
    assign doWrite = port.wrValid && port.wrReady;
    assign doLoad = (count_r != '0) && (!outValid_r || port.rdReady);
    assign port.rdValid = outValid_r;
    assign port.rdData = outData_r;

    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr_r] <= port.wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doWrite) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (doLoad) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(doWrite) - (AW+1)'(doLoad);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            outValid_r <= 1'b0;
            outData_r <= '0;
        end else if (doLoad) begin
            outValid_r <= 1'b1;
            outData_r <= mem[rdPtr_r];
        end else if (port.rdReady) begin
            outValid_r <= 1'b0;
        end
    end
endmodule

/* File: rtl/rcb_cell_bus_out.sv */
// Receive cell bus output: control register, cell buffer and link-side read logic
`timescale 1ns/10ps
module rcb_cell_bus_out #(
    parameter int FIFO_DEPTH = rcb_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic cellInValid,
    output logic cellInReady,
    input wire logic [15:0] cellInData,
    input wire logic rx_interface_clock,
    input wire logic read_enable_n,
    output logic [15:0] rx_cell_data_bus,
    output logic [1:0] rx_cell_data_bus_oe_n,
    output logic start_of_cell_out,
    output logic odd_parity_out,
    output logic cell_available_out,
    output logic fifo_empty_n_out,
    output logic level12Mode
);
    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [1:0] busWidth;
    logic [1:0] cellSize;
    logic [5:0] cellWords;
    logic busActive;
    logic width8;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r <= rcb_pkg::RX_CELL_BUS_CONTROL_RST;
        end else if (regWrEn && regAddr == rcb_pkg::RX_CELL_BUS_CONTROL_OFS) begin
            // Mode bits 6:4 are kept for software only (see RL19)
            ctrl_r <= regWrData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            regRdData <= (regAddr == rcb_pkg::RX_CELL_BUS_CONTROL_OFS) ? ctrl_r : 8'h00;
        end
    end

    assign busWidth = ctrl_r[rcb_pkg::CTRL_WIDTH_LSB +: 2];
    assign cellSize = ctrl_r[rcb_pkg::CTRL_SIZE_LSB +: 2];
    assign level12Mode = ctrl_r[rcb_pkg::CTRL_LEVEL_BIT]; // see RL2

    // Illegal pairings fall to zero words, which idles the bus like an inactive width
    always_comb begin
        cellWords = rcb_pkg::WORDS_NONE;
        case (busWidth)
            rcb_pkg::WIDTH_8: begin // see RL3
                if (cellSize == rcb_pkg::SIZE_52) begin // see RL6
                    cellWords = rcb_pkg::WORDS_8_52;
                end else if (cellSize == rcb_pkg::SIZE_53) begin // see RL8
                    cellWords = rcb_pkg::WORDS_8_53;
                end
            end
            rcb_pkg::WIDTH_16: begin
                if (cellSize == rcb_pkg::SIZE_52) begin // see RL7
                    cellWords = rcb_pkg::WORDS_16_52;
                end else if (cellSize == rcb_pkg::SIZE_54) begin
                    cellWords = rcb_pkg::WORDS_16_54;
                end
            end
            default: begin // see RL18
                cellWords = rcb_pkg::WORDS_NONE;
            end
        endcase
    end

    assign busActive = (cellWords != rcb_pkg::WORDS_NONE);
    assign width8 = (busWidth == rcb_pkg::WIDTH_8);

    // ------------------------------------------------------------
    // Word buffer
    // ------------------------------------------------------------
    rcb_fifo_if #(.WIDTH(rcb_pkg::BUS_W + 1)) buf_if ();

    rcb_fifo #(
        .WIDTH(rcb_pkg::BUS_W + 1),
        .DEPTH(FIFO_DEPTH)
    ) u_buf (
        .clk(clk),
        .rstn(rstn),
        .port(buf_if.store)
    );

    // Write side tags the last word of each cell so the read side needs no count of its own
    logic [5:0] wrCnt_r;
    logic wrLast;
    logic wrTake;

    assign wrLast = (wrCnt_r == cellWords - 6'h01);
    assign wrTake = cellInValid && buf_if.wrReady;
    assign buf_if.wrValid = cellInValid;
    assign buf_if.wrData = {wrLast, cellInData};
    assign cellInReady = buf_if.wrReady;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wrCnt_r <= 6'h00;
        end else if (!busActive) begin
            wrCnt_r <= 6'h00;
        end else if (wrTake) begin
            wrCnt_r <= wrLast ? 6'h00 : wrCnt_r + 6'h01; // see RL9
        end
    end

    // ------------------------------------------------------------
    // Link pin synchronisers
    // ------------------------------------------------------------
    logic lclkS1_r;
    logic lclkS2_r;
    logic lclkS3_r;
    logic renS1_r;
    logic renS2_r;
    logic linkRise;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            lclkS1_r <= 1'b0;
            lclkS2_r <= 1'b0;
            lclkS3_r <= 1'b0;
            renS1_r <= 1'b1;
            renS2_r <= 1'b1;
        end else begin
            lclkS1_r <= rx_interface_clock;
            lclkS2_r <= lclkS1_r;
            lclkS3_r <= lclkS2_r;
            renS1_r <= read_enable_n;
            renS2_r <= renS1_r;
        end
    end

    // Edge seen about two system clocks late; the link runs far slower
    assign linkRise = lclkS2_r && !lclkS3_r; // see RL16

    // ------------------------------------------------------------
    // Read side: one word per link edge while read enable is low
    // ------------------------------------------------------------
    rcb_pkg::rcb_rd_state_t rdState_r;
    logic [5:0] rdCnt_r;
    logic [rcb_pkg::CELL_CNT_W-1:0] cellCnt_r;
    logic pop;
    logic popLast;
    logic [15:0] word;

    // A word leaves only on a link edge with enable sampled low: no per-octet handshake
    assign pop = linkRise && !renS2_r && busActive && buf_if.rdValid; // see RL10
    assign popLast = pop && buf_if.rdData[rcb_pkg::BUS_W];
    assign buf_if.rdReady = pop;
    assign word = buf_if.rdData[15:0];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdState_r <= rcb_pkg::RCB_IDLE;
            rdCnt_r <= 6'h00;
        end else if (!busActive) begin
            rdState_r <= rcb_pkg::RCB_IDLE;
            rdCnt_r <= 6'h00;
        end else if (pop) begin
            case (rdState_r)
                rcb_pkg::RCB_IDLE: begin
                    rdState_r <= popLast ? rcb_pkg::RCB_IDLE : rcb_pkg::RCB_IN_CELL;
                    rdCnt_r <= popLast ? 6'h00 : 6'h01;
                end
                rcb_pkg::RCB_IN_CELL: begin
                    rdState_r <= popLast ? rcb_pkg::RCB_IDLE : rcb_pkg::RCB_IN_CELL;
                    rdCnt_r <= popLast ? 6'h00 : rdCnt_r + 6'h01; // see RL9
                end
                default: begin
                    rdState_r <= rcb_pkg::RCB_IDLE;
                    rdCnt_r <= 6'h00;
                end
            endcase
        end
    end

    // Data, start-of-cell and parity move together on the link edge
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_cell_data_bus <= 16'h0000;
            odd_parity_out <= 1'b1;
        end else if (pop) begin
            if (width8) begin
                rx_cell_data_bus <= {word[7:0], 8'h00}; // see RL4
                odd_parity_out <= ~^word[7:0]; // see RL15
            end else begin
                rx_cell_data_bus <= word; // see RL5
                odd_parity_out <= ~^word;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            start_of_cell_out <= 1'b0;
        end else if (pop) begin
            start_of_cell_out <= (rdState_r == rcb_pkg::RCB_IDLE); // see RL14
        end else if (linkRise) begin
            start_of_cell_out <= 1'b0;
        end
    end

    // Lane enables low while driving; upper lane is bit 1
    always_comb begin
        if (renS2_r || !busActive) begin
            rx_cell_data_bus_oe_n = 2'b11; // see RL17
        end else if (width8) begin
            rx_cell_data_bus_oe_n = 2'b01; // see RL4
        end else begin
            rx_cell_data_bus_oe_n = 2'b00; // see RL5
        end
    end

    // ------------------------------------------------------------
    // Cell accounting and cell-available
    // ------------------------------------------------------------
    logic wrCellDone;

    assign wrCellDone = wrTake && wrLast && busActive;

    // Write and read of a cell end in one cycle cancel, so neither event is lost
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cellCnt_r <= rcb_pkg::CELL_CNT_RST;
        end else if (!busActive) begin
            cellCnt_r <= rcb_pkg::CELL_CNT_RST;
        end else if (wrCellDone && !popLast) begin
            cellCnt_r <= cellCnt_r + 1'b1; // see RL11
        end else if (popLast && !wrCellDone && cellCnt_r != '0) begin
            cellCnt_r <= cellCnt_r - 1'b1; // see RL12
        end
    end

    // The buffer is shorter than a cell: a full buffer also flags a cell, since the
    // source then holds the rest and back-pressure paces it into the drained words
    assign cell_available_out = busActive && // see RL18
        ((cellCnt_r != '0) || buf_if.full); // see RL1
    assign fifo_empty_n_out = buf_if.rdValid;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_pop;
        linkRise && !renS2_r && busActive && buf_if.rdValid;
    endsequence

    sequence s_first_pop;
        s_pop ##0 (rdState_r == rcb_pkg::RCB_IDLE);
    endsequence

    a_clav_inactive_low: assert property (@(posedge clk) disable iff (!rstn) // see RL18
        !busActive |-> !cell_available_out)
        else $error("cell available raised while bus inactive");

    a_clav_cell_held: assert property (@(posedge clk) disable iff (!rstn) // see RL11
        (busActive && cellCnt_r != '0) |-> cell_available_out)
        else $error("cell available low with a complete cell waiting");

    a_clav_drop_empty: assert property (@(posedge clk) disable iff (!rstn) // see RL12
        (cellCnt_r == '0 && !buf_if.full) |-> !cell_available_out)
        else $error("cell available high without a complete cell");

    a_soc_first_word: assert property (@(posedge clk) disable iff (!rstn) // see RL14
        s_first_pop |=> start_of_cell_out)
        else $error("start of cell missing on first word");

    a_soc_one_period: assert property (@(posedge clk) disable iff (!rstn) // see RL14
        (start_of_cell_out && linkRise && !pop) |=> !start_of_cell_out)
        else $error("start of cell held past one link period");

    a_soc_mid_cell: assert property (@(posedge clk) disable iff (!rstn) // see RL14
        (s_pop ##0 (rdState_r == rcb_pkg::RCB_IN_CELL)) |=> !start_of_cell_out)
        else $error("start of cell raised inside a cell");

    a_parity_odd: assert property (@(posedge clk) disable iff (!rstn) // see RL15
        s_pop |=> (width8 ? (^{odd_parity_out, rx_cell_data_bus[15:8]})
                          : (^{odd_parity_out, rx_cell_data_bus})))
        else $error("parity bit does not make odd parity");

    a_data_on_edge: assert property (@(posedge clk) disable iff (!rstn) // see RL16
        $changed(rx_cell_data_bus) |-> $past(linkRise))
        else $error("data bus changed away from a link edge");

    a_bus_float: assert property (@(posedge clk) disable iff (!rstn) // see RL17
        renS2_r |-> rx_cell_data_bus_oe_n == 2'b11)
        else $error("data bus driven while read enable high");

    a_lanes_8bit: assert property (@(posedge clk) disable iff (!rstn) // see RL4
        (busActive && width8 && !renS2_r) |-> rx_cell_data_bus_oe_n == 2'b01)
        else $error("wrong lanes driven in 8-bit width");

    a_lanes_16bit: assert property (@(posedge clk) disable iff (!rstn) // see RL5
        (busActive && !width8 && !renS2_r) |-> rx_cell_data_bus_oe_n == 2'b00)
        else $error("not all lanes driven in 16-bit width");

    a_cell_len_exact: assert property (@(posedge clk) disable iff (!rstn) // see RL9
        (s_pop ##0 buf_if.rdData[rcb_pkg::BUS_W]) |-> (rdCnt_r == cellWords - 6'h01))
        else $error("cell end word not at configured length");

    a_level_field: assert property (@(posedge clk) disable iff (!rstn) // see RL2
        (regWrEn && regAddr == rcb_pkg::RX_CELL_BUS_CONTROL_OFS)
        |=> level12Mode == $past(regWrData[rcb_pkg::CTRL_LEVEL_BIT]))
        else $error("level select not taken from control bit 7");

    a_soc_needs_pop: assert property (@(posedge clk) disable iff (!rstn) // see RL14
        $rose(start_of_cell_out) |-> $past(pop))
        else $error("start of cell rose without a popped word");

    a_parity_stable: assert property (@(posedge clk) disable iff (!rstn) // see RL15
        !pop |=> $stable(odd_parity_out))
        else $error("parity changed without a new word");

    a_lanes_low_zero: assert property (@(posedge clk) disable iff (!rstn) // see RL4
        (s_pop ##0 width8) |=> rx_cell_data_bus[7:0] == 8'h00)
        else $error("lower lanes carry data in 8-bit width");

    a_word_16bit: assert property (@(posedge clk) disable iff (!rstn) // see RL5
        (s_pop ##0 !width8) |=> rx_cell_data_bus == $past(word))
        else $error("16-bit word not presented whole");

    // Reconfiguring in mid-cell is not supported, so the count never passes the length
    a_wr_cnt_bound: assert property (@(posedge clk) disable iff (!rstn) // see RL9
        busActive |-> wrCnt_r < cellWords)
        else $error("write count beyond configured cell length");

    a_clav_new_cell: assert property (@(posedge clk) disable iff (!rstn) // see RL11
        (busActive && wrCellDone && !popLast) |=> cell_available_out)
        else $error("cell available low after a cell completed");

    a_clav_last_cell: assert property (@(posedge clk) disable iff (!rstn) // see RL12
        (popLast && !wrCellDone && cellCnt_r == 8'h01 && !buf_if.full)
        |=> !cell_available_out)
        else $error("cell available held after the last cell left");

endmodule

/* File: dv/rcb_atm_reader.sv */
// Model of the ATM layer reader on the far side of the cell bus
`timescale 1ns/10ps
module rcb_atm_reader (
    output logic linkClk,
    output logic readEnN,
    input wire logic [15:0] bus,
    input wire logic soc,
    input wire logic par,
    input wire logic [1:0] oeN
);
    logic [15:0] capData [0:63];
    logic capSoc [0:63];
    logic capPar [0:63];
    logic [1:0] capOe [0:63];

    initial begin
        linkClk = 1'b0;
        readEnN = 1'b1;
    end

    // ------------------------------------------------------------
    // One cell per call
    // ------------------------------------------------------------
    // The clock runs only inside a frame; each rise samples the word
    // popped on the rise before, since the device answers a few ns late
    task automatic read_cell(input int n, input int gap);
        readEnN = 1'b0;
        #(gap);
        for (int i = 0; i <= n; i++) begin
            // Let go just ahead of the rise after the last word, so that rise pops nothing
            if (i == n) begin
                readEnN = 1'b1;
            end
            linkClk = 1'b1;
            if (i > 0) begin
                capData[i-1] = bus;
                capSoc[i-1] = soc;
                capPar[i-1] = par;
                capOe[i-1] = oeN;
            end
            #24;
            linkClk = 1'b0;
            #24;
        end
    endtask
endmodule

/* File: dv/test_rcb_cell_bus_out.sv */
// Self-checking bench for the receive cell bus output
`timescale 1ns/10ps
module test_rcb_cell_bus_out;
    localparam logic [15:0] OFS = rcb_pkg::RX_CELL_BUS_CONTROL_OFS;
    // Legal {width, size} pairs, then inactive and illegal control values
    localparam logic [3:0] CFG [4] = '{4'h4, 4'h5, 4'h8, 4'hA};
    localparam logic [7:0] BAD [4] = '{8'h80, 8'h8C, 8'h89, 8'h87};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regRdData;
    logic cellInValid = 1'b0;
    logic cellInReady;
    logic [15:0] cellInData = 16'h0000;
    logic linkClk;
    logic readEnN;
    logic [15:0] bus;
    logic [1:0] oeN;
    logic soc;
    logic par;
    logic clav;
    logic emptyN;
    logic lvl12;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    logic [15:0] expQ [$];

    rcb_cell_bus_out dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .cellInValid(cellInValid), .cellInReady(cellInReady), .cellInData(cellInData),
        .rx_interface_clock(linkClk), .read_enable_n(readEnN), .rx_cell_data_bus(bus),
        .rx_cell_data_bus_oe_n(oeN), .start_of_cell_out(soc), .odd_parity_out(par),
        .cell_available_out(clav), .fifo_empty_n_out(emptyN), .level12Mode(lvl12));

    rcb_atm_reader atm (.linkClk(linkClk), .readEnN(readEnN), .bus(bus), .soc(soc),
        .par(par), .oeN(oeN));

    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] got);
        check_count++;
        if (got !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, e, got);
        end
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clk);
        #1;
        regWrEn = 1'b0;
    endtask

    task automatic reg_rd(input logic [15:0] a);
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge clk);
        #1;
        regRdEn = 1'b0;
    endtask

    function automatic int cell_words(input logic [3:0] c);
        int oct = (c[1:0] == 2'h0) ? 52 : (c[1:0] == 2'h1) ? 53 : 54;
        return c[3] ? oct / 2 : oct;
    endfunction

    // In 8-bit width the octet enters on 7:0 and leaves on 15:8
    task automatic push(input int n, input bit wide);
        logic [15:0] w;
        for (int i = 0; i < n; i++) begin
            w = 16'($urandom);
            if (!wide) begin
                w[15:8] = 8'h00;
            end
            expQ.push_back(wide ? w : {w[7:0], 8'h00});
            cellInData = w;
            cellInValid = 1'b1;
            #1;
            while (cellInReady !== 1'b1) begin
                @(posedge clk);
                #2;
            end
            @(posedge clk);
            #1;
        end
        cellInValid = 1'b0;
    endtask

    task automatic read_check(input int n, input bit wide);
        logic [15:0] e;
        int t = 0;
        while (clav !== 1'b1 && t < 3000) begin
            @(posedge clk);
            #1;
            t++;
        end
        chk("clav up", 16'h0001, {15'h0000, clav});
        chk("not empty", 16'h0001, {15'h0000, emptyN});
        atm.read_cell(n, $urandom_range(300, 40));
        for (int i = 0; i < n; i++) begin
            e = expQ.pop_front();
            chk("data", e, atm.capData[i]);
            chk("parity", {15'h0000, ~^e}, {15'h0000, atm.capPar[i]});
            chk("soc", {15'h0000, i == 0}, {15'h0000, atm.capSoc[i]});
            chk("lanes", wide ? 16'h0000 : 16'h0001, {14'h0000, atm.capOe[i]});
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] ctrl;
        int words;
        void'($urandom(15));
        repeat (10) @(posedge clk);
        #1;
        rstn = 1'b1;
        reg_wr(16'h0402, 8'h4A);
        reg_rd(OFS);
        chk("ctrl reset", {8'h00, rcb_pkg::RX_CELL_BUS_CONTROL_RST}, {8'h00, regRdData});
        reg_rd(16'h0402);
        chk("unmapped", 16'h0000, {8'h00, regRdData});
        chk("clav idle", 16'h0000, {15'h0000, clav});
        chk("oe idle", 16'h0003, {14'h0000, oeN});
        foreach (CFG[k]) begin
            ctrl = {4'($urandom), CFG[k]};
            reg_wr(OFS, ctrl);
            reg_rd(OFS);
            chk("ctrl", {8'h00, ctrl}, {8'h00, regRdData});
            chk("level", {15'h0000, ctrl[7]}, {15'h0000, lvl12});
            words = cell_words(CFG[k]);
            fork
                push(2 * words, CFG[k][3]);
                begin
                    read_check(words, CFG[k][3]);
                    read_check(words, CFG[k][3]);
                end
            join
            repeat (10) @(posedge clk);
            #1;
            chk("clav drained", 16'h0000, {15'h0000, clav});
            chk("drained", 16'h0000, {15'h0000, emptyN});
            chk("oe released", 16'h0003, {14'h0000, oeN});
        end
        foreach (BAD[k]) begin
            reg_wr(OFS, BAD[k]);
            push(3, 1'b1);
            repeat (40) @(posedge clk);
            #1;
            chk("clav off", 16'h0000, {15'h0000, clav});
        end
        report_and_stop();
    end
endmodule
